/* File: design/wdp_watchdog.sv */
// Watchdog with count source protection and AXI4-Lite registers
`timescale 1ns/10ps
module wdp_watchdog #(
  parameter logic [7:0] OPT_IMAGE = wdp_pkg::WDP_OPT_ERASED
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rstn_in,
  input  wire logic [wdp_pkg::WDP_AW-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic [1:0]                     s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [wdp_pkg::WDP_AW-1:0] s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  input  wire logic                      osc_clk_in,
  input  wire logic                      wait_mode_in,
  input  wire logic                      hold_in,
  output logic                           irq_out,
  output logic                           wdt_reset_out,
  output logic                           rom_protect_out,
  output logic                           osc_on_out,
  output logic                           stop_req_out
);
  import wdp_pkg::*;

  typedef struct packed {
    logic                 aw_hold;
    logic [WDP_AW-1:0]    aw_addr;
    logic                 w_hold;
    logic [7:0]           w_data;
    logic                 w_ok;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [WDP_CNT_W-1:0] cnt;
    logic [WDP_PRE_W-1:0] pre;
    logic                 run;
    logic                 prot;
    logic                 armed;
    logic                 psel;
    logic                 urs;
    logic                 stop_b;
    logic                 osc_on;
    logic [7:0]           opt;
    logic [WDP_NSTS-1:0]  sts;
    logic [WDP_NSTS-1:0]  ien;
    logic                 irq;
    logic                 wrst;
    logic                 romp;
  } wdp_core_st_t;

  wdp_core_st_t         st_r;
  wdp_core_st_t         st_nxt;
  logic                 osc_rise;
  logic                 pause;
  logic                 cnt_run;
  logic                 pre_wrap;
  logic                 src_tick;
  logic                 unf;
  logic                 wr_go;
  logic                 wen;
  logic                 set_unf;
  logic                 set_rfr;
  wdp_reg_t             wsel;
  logic [7:0]           wd;
  logic [WDP_PRE_W-1:0] pre_last;
  logic [WDP_CNT_W-1:0] reload;

  // Oscillator is another clock; it only ever yields a tick pulse
  wdp_sync u_osc_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .async_in   (osc_clk_in),
    .rise_out   (osc_rise)
  );

  // Register read view; write-only registers read as zero
  function automatic logic [31:0] rd_word(input wdp_reg_t r,
                                          input wdp_core_st_t s);
    logic [31:0] v;
    v = '0;
    if (r == WDP_R_CTRL) v[WDP_B_PSEL] = s.psel;
    else if (r == WDP_R_PMODE) v[WDP_B_URS] = s.urs;
    else if (r == WDP_R_CMODE) begin
      v[WDP_B_STOP]   = s.stop_b;
      v[WDP_B_OSCOFF] = ~s.osc_on;
    end
    else if (r == WDP_R_PROT) v[WDP_B_PROT] = s.prot;
    else if (r == WDP_R_OPT) v[7:0] = s.opt;
    else if (r == WDP_R_STAT) v[WDP_NSTS-1:0] = s.sts;
    else if (r == WDP_R_IEN) v[WDP_NSTS-1:0] = s.ien;
    else if (r == WDP_R_COUNT) v[WDP_CNT_W-1:0] = s.cnt;
    return v;
  endfunction : rd_word

  // Whole next-state computation
  always_comb begin
    st_nxt  = st_r;
    set_unf = 1'b0;
    set_rfr = 1'b0;

    // Write address and data may arrive in either order
    if (s_axi_awvalid_in && st_r.awready) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st_r.wready) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_data = s_axi_wdata_in[7:0];
      st_nxt.w_ok   = s_axi_wstrb_in[0];
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    wr_go = st_r.aw_hold & st_r.w_hold & ~st_r.bvalid;
    wen   = wr_go & st_r.w_ok;
    wsel  = wdp_decode(st_r.aw_addr);
    wd    = st_r.w_data;

    // Protection removes every pause condition
    pause    = ~st_r.prot &
               (st_r.stop_b | wait_mode_in | hold_in);
    cnt_run  = st_r.run & ~pause;
    pre_last = st_r.psel ? WDP_PRE_LAST_HI
                         : WDP_PRE_LAST_LO;
    // >= so a ratio change mid-count cannot strand the prescaler
    pre_wrap = st_r.pre >= pre_last;
    src_tick = cnt_run & (st_r.prot ? osc_rise : pre_wrap);
    reload   = st_r.prot ? WDP_CNT_PROT : WDP_CNT_FULL;
    unf      = src_tick & (st_r.cnt == '0);

    // Prescaler only runs on the CPU clock source
    if (cnt_run && !st_r.prot) begin
      st_nxt.pre = pre_wrap ? '0 : st_r.pre + 1'b1;
    end

    // Down-count, reload on underflow
    if (src_tick) begin
      st_nxt.cnt = unf ? reload : st_r.cnt - 1'b1;
    end
    if (unf) begin
      if (st_r.prot || st_r.urs) begin
        st_nxt.wrst = 1'b1;
      end else begin
        set_unf = 1'b1;
      end
    end

    // Write completes once both halves are held
    if (wr_go) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = (wsel == WDP_R_NONE) ? WDP_RESP_SLVERR
                                             : WDP_RESP_OKAY;
      if (wsel != WDP_R_REFRESH) begin
        st_nxt.armed = 1'b0;
      end
    end

    // Register write effects; bus write wins over a same-cycle tick
    if (wen) begin
      if (wsel == WDP_R_REFRESH) begin
        if (wd == WDP_REFRESH_ARM) begin
          st_nxt.armed = 1'b1;
        end else begin
          st_nxt.armed = 1'b0;
          if (wd == WDP_REFRESH_FIRE && st_r.armed) begin
            st_nxt.cnt = reload;
            set_rfr    = 1'b1;
          end
        end
      end
      else if (wsel == WDP_R_START) begin
        st_nxt.run = 1'b1;
      end
      else if (wsel == WDP_R_CTRL) begin
        st_nxt.psel = wd[WDP_B_PSEL];
      end
      else if (wsel == WDP_R_PMODE) begin
        // Protected mode pins underflow to reset
        if (!st_r.prot) begin
          st_nxt.urs = wd[WDP_B_URS];
        end
      end
      else if (wsel == WDP_R_CMODE) begin
        if (!st_r.prot) begin
          st_nxt.stop_b = wd[WDP_B_STOP];
          st_nxt.osc_on = ~wd[WDP_B_OSCOFF];
        end
      end
      else if (wsel == WDP_R_PROT) begin
        // One-way: once enabled it stays on until reset
        if (wd[WDP_B_PROT] && !st_r.prot) begin
          st_nxt.prot   = 1'b1;
          st_nxt.cnt    = WDP_CNT_PROT;
          st_nxt.osc_on = 1'b1;
          st_nxt.urs    = 1'b1;
          st_nxt.stop_b = 1'b0;
          st_nxt.pre    = '0;
        end
      end
      else if (wsel == WDP_R_IEN) begin
        st_nxt.ien = wd[WDP_NSTS-1:0];
      end
      else if (wsel == WDP_R_ICLR) begin
        st_nxt.sts = st_r.sts & ~wd[WDP_NSTS-1:0];
      end
    end

    // Events set after the clear so a coincident event survives
    if (set_unf) begin
      st_nxt.sts[WDP_S_UNF] = 1'b1;
    end
    if (set_rfr) begin
      st_nxt.sts[WDP_S_RFR] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.sts & st_nxt.ien);

    // Read channel, one outstanding
    if (s_axi_arvalid_in && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word(wdp_decode(s_axi_araddr_in), st_r);
      st_nxt.rresp  = (wdp_decode(s_axi_araddr_in) == WDP_R_NONE)
                      ? WDP_RESP_SLVERR : WDP_RESP_OKAY;
    end else if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end

    // Readies drop while a response waits
    st_nxt.awready = ~st_nxt.aw_hold & ~st_nxt.bvalid;
    st_nxt.wready  = ~st_nxt.w_hold & ~st_nxt.bvalid;
    st_nxt.arready = ~st_nxt.rvalid;
    st_nxt.romp    = ~st_r.opt[WDP_B_ROMP];
  end

  // Reset state comes from the flash option image
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r        <= '0;
      st_r.opt    <= OPT_IMAGE;
      st_r.run    <= ~OPT_IMAGE[WDP_B_AUTOOFF];
      st_r.prot   <= ~OPT_IMAGE[WDP_B_PINIT];
      st_r.urs    <= ~OPT_IMAGE[WDP_B_PINIT];
      st_r.cnt    <= OPT_IMAGE[WDP_B_PINIT] ? WDP_CNT_FULL
                                             : WDP_CNT_PROT;
      st_r.osc_on <= 1'b1;
      st_r.romp   <= ~OPT_IMAGE[WDP_B_ROMP];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready_out = st_r.awready;
  assign s_axi_wready_out  = st_r.wready;
  assign s_axi_bresp_out   = st_r.bresp;
  assign s_axi_bvalid_out  = st_r.bvalid;
  assign s_axi_arready_out = st_r.arready;
  assign s_axi_rdata_out   = st_r.rdata;
  assign s_axi_rresp_out   = st_r.rresp;
  assign s_axi_rvalid_out  = st_r.rvalid;
  assign irq_out           = st_r.irq;
  assign wdt_reset_out     = st_r.wrst;
  assign rom_protect_out   = st_r.romp;
  assign osc_on_out        = st_r.osc_on;
  assign stop_req_out      = st_r.stop_b;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // Counter steps by exactly one per tick
  chk_cnt_step: assert property (
    (src_tick && st_r.cnt != '0 && !wr_go)
    |=> st_r.cnt == $past(st_r.cnt) - 15'h0001)
    else $error("counter did not step by one");

  // Protected count moves only on oscillator edges
  chk_prot_source: assert property (
    (st_r.prot && !osc_rise && !wr_go) |=> $stable(st_r.cnt))
    else $error("protected count moved without oscillator edge");

  // Halted timer holds its value
  chk_halt_hold: assert property (
    (!st_r.run && !wr_go) |=> $stable(st_r.cnt))
    else $error("halted timer counted");

  // Unprotected pause freezes count and prescaler
  chk_pause_freeze: assert property (
    (!st_r.prot && pause && !wr_go)
    |=> $stable(st_r.cnt) && $stable(st_r.pre))
    else $error("count moved during pause");

  // Armed FFh write reloads the counter
  chk_refresh_load: assert property (
    (wen && wsel == WDP_R_REFRESH && wd == WDP_REFRESH_FIRE
     && st_r.armed)
    |=> st_r.cnt == (st_r.prot ? WDP_CNT_PROT : WDP_CNT_FULL))
    else $error("refresh did not reload");

  // Any non-00h refresh write disarms
  chk_refresh_disarm: assert property (
    (wen && wsel == WDP_R_REFRESH && wd != WDP_REFRESH_ARM)
    |=> !st_r.armed)
    else $error("refresh sequence stayed armed");

  // Underflow outcome follows mode and select bit
  chk_unf_reset: assert property (
    (unf && (st_r.prot || st_r.urs)) |=> wdt_reset_out [*2])
    else $error("underflow reset not raised");

  chk_unf_irq: assert property (
    (unf && !st_r.prot && !st_r.urs)
    |=> st_r.sts[WDP_S_UNF] && $stable(wdt_reset_out))
    else $error("underflow interrupt not flagged");

  // Entering protection loads and forces settings
  chk_prot_entry: assert property (
    (wen && wsel == WDP_R_PROT && wd[WDP_B_PROT] && !st_r.prot)
    |=> st_r.prot && st_r.cnt == WDP_CNT_PROT && st_r.urs
        && osc_on_out)
    else $error("protection entry incomplete");

  // Protection keeps oscillator on and stop off
  chk_prot_lock: assert property (
    st_r.prot |-> osc_on_out && !stop_req_out)
    else $error("protection lock broken");

  // Start write releases a halted timer
  chk_start_run: assert property (
    (wen && wsel == WDP_R_START) |=> st_r.run)
    else $error("start write ignored");

  // Interrupt level matches enabled status in the same cycle
  chk_irq_level: assert property (
    ##1 irq_out == (|(st_r.sts & st_r.ien)))
    else $error("interrupt level mismatch");

  // Code protect output is the inverse of the option bit
  chk_rom_prot: assert property (
    rom_protect_out == ~st_r.opt[WDP_B_ROMP])
    else $error("code protect output wrong");

endmodule : wdp_watchdog

/* File: design/wdp_pkg.sv */
// Package: register map, field layout, counts and decode of the watchdog
package wdp_pkg;

  localparam int WDP_AW    = 18;
  localparam int WDP_CNT_W = 15;
  localparam int WDP_PRE_W = 7;
  localparam int WDP_NSTS  = 2;

  // Own word registers, byte addresses
  localparam logic [WDP_AW-1:0] WDP_ADDR_REFRESH = 18'h00000;
  localparam logic [WDP_AW-1:0] WDP_ADDR_START   = 18'h00004;
  localparam logic [WDP_AW-1:0] WDP_ADDR_CTRL    = 18'h00008;
  localparam logic [WDP_AW-1:0] WDP_ADDR_PMODE   = 18'h0000C;
  localparam logic [WDP_AW-1:0] WDP_ADDR_CMODE   = 18'h00010;
  localparam logic [WDP_AW-1:0] WDP_ADDR_STAT    = 18'h00014;
  localparam logic [WDP_AW-1:0] WDP_ADDR_IEN     = 18'h00018;
  localparam logic [WDP_AW-1:0] WDP_ADDR_ICLR    = 18'h0001C;
  localparam logic [WDP_AW-1:0] WDP_ADDR_COUNT   = 18'h00020;
  // Printed offsets are word indices; byte address is four times
  localparam logic [15:0] WDP_IDX_PROT = 16'h037C;
  localparam logic [15:0] WDP_IDX_OPT  = 16'hFFFF;
  localparam logic [WDP_AW-1:0] WDP_ADDR_PROT = {WDP_IDX_PROT, 2'h0};
  localparam logic [WDP_AW-1:0] WDP_ADDR_OPT  = {WDP_IDX_OPT, 2'h0};

  // Bit positions
  localparam int WDP_B_PSEL    = 7;
  localparam int WDP_B_URS     = 2;
  localparam int WDP_B_STOP    = 0;
  localparam int WDP_B_OSCOFF  = 4;
  localparam int WDP_B_PROT    = 7;
  localparam int WDP_B_AUTOOFF = 0;
  localparam int WDP_B_ROMP    = 3;
  localparam int WDP_B_PINIT   = 7;
  localparam int WDP_S_UNF     = 0;
  localparam int WDP_S_RFR     = 1;

  // Values and counts
  localparam logic [7:0] WDP_REFRESH_ARM  = 8'h00;
  localparam logic [7:0] WDP_REFRESH_FIRE = 8'hFF;
  localparam logic [7:0] WDP_OPT_ERASED   = 8'hFF;
  localparam logic [WDP_CNT_W-1:0] WDP_CNT_FULL = 15'h7FFF;
  localparam logic [WDP_CNT_W-1:0] WDP_CNT_PROT = 15'h0FFF;
  localparam int WDP_DIV_LO = 16;
  localparam int WDP_DIV_HI = 128;
  localparam logic [WDP_PRE_W-1:0] WDP_PRE_LAST_LO =
    WDP_PRE_W'(WDP_DIV_LO - 1);
  localparam logic [WDP_PRE_W-1:0] WDP_PRE_LAST_HI =
    WDP_PRE_W'(WDP_DIV_HI - 1);
  localparam logic [1:0] WDP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDP_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    WDP_R_NONE, WDP_R_REFRESH, WDP_R_START, WDP_R_CTRL, WDP_R_PMODE,
    WDP_R_CMODE, WDP_R_PROT, WDP_R_OPT, WDP_R_STAT, WDP_R_IEN,
    WDP_R_ICLR, WDP_R_COUNT
  } wdp_reg_t;

  // Shared by the read and the write path
  function automatic wdp_reg_t wdp_decode(input logic [WDP_AW-1:0] a);
    if (a == WDP_ADDR_REFRESH) return WDP_R_REFRESH;
    else if (a == WDP_ADDR_START) return WDP_R_START;
    else if (a == WDP_ADDR_CTRL) return WDP_R_CTRL;
    else if (a == WDP_ADDR_PMODE) return WDP_R_PMODE;
    else if (a == WDP_ADDR_CMODE) return WDP_R_CMODE;
    else if (a == WDP_ADDR_PROT) return WDP_R_PROT;
    else if (a == WDP_ADDR_OPT) return WDP_R_OPT;
    else if (a == WDP_ADDR_STAT) return WDP_R_STAT;
    else if (a == WDP_ADDR_IEN) return WDP_R_IEN;
    else if (a == WDP_ADDR_ICLR) return WDP_R_ICLR;
    else if (a == WDP_ADDR_COUNT) return WDP_R_COUNT;
    else return WDP_R_NONE;
  endfunction : wdp_decode

endpackage : wdp_pkg

/* File: design/wdp_sync.sv */
// Two-flop synchroniser with registered rising-edge pulse
`timescale 1ns/10ps
module wdp_sync (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic async_in,
  output logic      rise_out
);
  import wdp_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } wdp_sync_st_t;

  wdp_sync_st_t st_r;
  wdp_sync_st_t st_nxt;

  // First stage feeds only the second; edge taken after that
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = async_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise_out = st_r.rise;

endmodule : wdp_sync

/* File: dv/test_wdp_watchdog.sv */
// Self-checking bench for the watchdog block over its register bus
`timescale 1ns/10ps
module test_wdp_watchdog;
  import wdp_pkg::*;

  logic              ref_clk_in = 1'b0;
  logic              rstn_in    = 1'b0;
  logic [WDP_AW-1:0] awaddr     = '0;
  logic [WDP_AW-1:0] araddr     = '0;
  logic [31:0]       wdata      = '0;
  logic              awvalid    = 1'b0;
  logic              wvalid     = 1'b0;
  logic              bready     = 1'b0;
  logic              arvalid    = 1'b0;
  logic              rready     = 1'b0;
  logic              osc_clk    = 1'b0;
  logic              wait_mode  = 1'b0;
  logic              hold       = 1'b0;
  logic              awready;
  logic              wready;
  logic              bvalid;
  logic              arready;
  logic              rvalid;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic [31:0]       rdata;
  logic              irq;
  logic              wdt_rst;
  logic              rom_prot;
  logic              osc_on;
  logic              stop_req;
  int                bad_count   = 0;
  int                checks_done = 0;
  logic [1:0]        exp_b[$];
  logic [65:0]       exp_r[$];
  logic [65:0]       mon_e;
  logic [31:0]       lfsr = 32'h12C9BBCA;
  logic [31:0]       c1;
  logic [31:0]       c2;
  int                osc_half    = 4000;
  int                n_wait;

  // 125 MHz core clock; slow oscillator free-running and unrelated
  always #4 ref_clk_in = ~ref_clk_in;
  always #(osc_half) osc_clk = ~osc_clk;

  wdp_watchdog #(.OPT_IMAGE(8'hFF)) dut_u (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .osc_clk_in(osc_clk),
    .wait_mode_in(wait_mode), .hold_in(hold), .irq_out(irq),
    .wdt_reset_out(wdt_rst), .rom_protect_out(rom_prot),
    .osc_on_out(osc_on), .stop_req_out(stop_req));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic timeout(input string nm);
    bad_count++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    finish_test();
  endtask : timeout

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  // Bus write; bresp is judged by the monitor
  task automatic wr(input logic [WDP_AW-1:0] a, input logic [7:0] d,
                    input logic [1:0] er = WDP_RESP_OKAY);
    int n;
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    forever begin
      @(posedge ref_clk_in);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      if (n > 100) timeout("write answer");
    end
    bready <= 1'b0;
    // Edge gap so the next request never re-drives in this step
    @(posedge ref_clk_in);
  endtask : wr

  // Bus read; expected data under mask is judged by the monitor
  task automatic rd(input logic [WDP_AW-1:0] a, input logic [31:0] ed,
                    input logic [31:0] em, input logic [1:0] er,
                    output logic [31:0] got);
    int n;
    exp_r.push_back({er, em, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    forever begin
      @(posedge ref_clk_in);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      if (n > 100) timeout("read answer");
    end
    got = rdata;
    rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask : rd

  task automatic rx(input logic [WDP_AW-1:0] a, input logic [31:0] ed);
    logic [31:0] g;
    rd(a, ed, 32'hFFFFFFFF, WDP_RESP_OKAY, g);
  endtask : rx

  // Ticks seen across w+3 edges between the two read takes
  task automatic rate(input int w, input int lo, input int hi);
    int d;
    rd(WDP_ADDR_COUNT, 32'h0, 32'h0, WDP_RESP_OKAY, c1);
    repeat (w) @(posedge ref_clk_in);
    rd(WDP_ADDR_COUNT, 32'h0, 32'h0, WDP_RESP_OKAY, c2);
    d = int'(c1[14:0]) - int'(c2[14:0]);
    // An unknown count would read as zero ticks in the int arithmetic
    check("count known", 32'h0, 32'($isunknown({c1, c2})));
    check("count ticks", 32'h1, 32'(d >= lo && d <= hi));
  endtask : rate

  // Monitor: oldest note per handshake against what the block answered
  always @(posedge ref_clk_in) begin
    if (rvalid === 1'b1 && rready) begin
      mon_e = exp_r.pop_front();
      check("rresp", 32'(mon_e[65:64]), 32'(rresp));
      check("rdata", mon_e[31:0] & mon_e[63:32], rdata & mon_e[63:32]);
    end
    if (bvalid === 1'b1 && bready) begin
      check("bresp", 32'(exp_b.pop_front()), 32'(bresp));
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    // Erased option byte: halted, unprotected, no code protection
    rx(WDP_ADDR_COUNT, 32'h7FFF);
    rate(253, 0, 0);
    rx(WDP_ADDR_OPT, 32'hFF);
    rx(WDP_ADDR_PROT, 32'h0);
    rx(WDP_ADDR_CTRL, 32'h0);
    rx(WDP_ADDR_PMODE, 32'h0);
    rx(WDP_ADDR_CMODE, 32'h0);
    rx(WDP_ADDR_STAT, 32'h0);
    rx(WDP_ADDR_IEN, 32'h0);
    check("osc on", 32'h1, 32'(osc_on));
    check("rom protect", 32'h0, 32'(rom_prot));
    rd(18'h00024, 32'h0, 32'hFFFFFFFF, WDP_RESP_SLVERR, c1);
    wr(18'h00024, 8'h5A, WDP_RESP_SLVERR);
    wr(WDP_ADDR_PMODE, 8'h04);
    rx(WDP_ADDR_PMODE, 32'h4);
    wr(WDP_ADDR_PMODE, 8'h00);
    end_test("reset");
    // Any start value releases the halted counter
    lfsr = lfsr_next(lfsr);
    wr(WDP_ADDR_START, lfsr[7:0]);
    rate(125, 7, 9);
    wr(WDP_ADDR_CTRL, 8'h80);
    rx(WDP_ADDR_CTRL, 32'h80);
    rate(509, 3, 5);
    wr(WDP_ADDR_CTRL, 8'h00);
    end_test("prescale");
    // Unprotected count pauses in wait, hold and stop
    wait_mode <= 1'b1;
    rate(253, 0, 0);
    wait_mode <= 1'b0;
    hold <= 1'b1;
    rate(253, 0, 0);
    hold <= 1'b0;
    wr(WDP_ADDR_CMODE, 8'h01);
    check("stop req", 32'h1, 32'(stop_req));
    rate(253, 0, 0);
    wr(WDP_ADDR_CMODE, 8'h10);
    check("osc on", 32'h0, 32'(osc_on));
    wr(WDP_ADDR_CMODE, 8'h00);
    end_test("pause");
    // Refresh only by 00h straight before FFh; event raises the interrupt
    wr(WDP_ADDR_IEN, 8'h02);
    lfsr = lfsr_next(lfsr);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_ARM);
    wr(WDP_ADDR_REFRESH, (lfsr[7:0] | 8'h01) & 8'h7F);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_FIRE);
    rx(WDP_ADDR_STAT, 32'h0);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_ARM);
    wr(WDP_ADDR_IEN, 8'h02);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_FIRE);
    rx(WDP_ADDR_STAT, 32'h0);
    check("irq", 32'h0, 32'(irq));
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_ARM);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_FIRE);
    rd(WDP_ADDR_COUNT, 32'h7FFE, 32'h7FFE, WDP_RESP_OKAY, c1);
    rx(WDP_ADDR_STAT, 32'h2);
    check("irq", 32'h1, 32'(irq));
    wr(WDP_ADDR_ICLR, 8'h02);
    rx(WDP_ADDR_STAT, 32'h0);
    check("irq", 32'h0, 32'(irq));
    wr(WDP_ADDR_IEN, 8'h00);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_ARM);
    wr(WDP_ADDR_REFRESH, WDP_REFRESH_FIRE);
    rx(WDP_ADDR_STAT, 32'h2);
    check("irq masked", 32'h0, 32'(irq));
    wr(WDP_ADDR_ICLR, 8'h02);
    end_test("refresh");
    // Protection entry, lock-out and oscillator-driven count
    wr(WDP_ADDR_PROT, 8'h80);
    rd(WDP_ADDR_COUNT, 32'h0FFE, 32'h7FFE, WDP_RESP_OKAY, c1);
    rx(WDP_ADDR_PROT, 32'h80);
    rx(WDP_ADDR_PMODE, 32'h4);
    wr(WDP_ADDR_CMODE, 8'h11);
    check("stop req", 32'h0, 32'(stop_req));
    check("osc on", 32'h1, 32'(osc_on));
    wr(WDP_ADDR_PMODE, 8'h00);
    rx(WDP_ADDR_PMODE, 32'h4);
    wr(WDP_ADDR_PROT, 8'h00);
    rx(WDP_ADDR_PROT, 32'h80);
    wait_mode <= 1'b1;
    hold <= 1'b1;
    rate(2997, 2, 4);
    wait_mode <= 1'b0;
    hold <= 1'b0;
    check("wdt reset", 32'h0, 32'(wdt_rst));
    end_test("protect");
    // Faster oscillator so the protected underflow falls inside the run
    osc_half = 40;
    n_wait = 0;
    while (wdt_rst !== 1'b1 && n_wait < 60000) begin
      @(posedge ref_clk_in);
      n_wait++;
    end
    check("wdt reset", 32'h1, 32'(wdt_rst));
    rx(WDP_ADDR_STAT, 32'h0);
    end_test("underflow");
    finish_test();
  end
endmodule : test_wdp_watchdog
